// ---- rtl/idwp_top.sv ----
// Purpose: Interrupt acceptance path with wake detector, pending logic and arbiter.
// Assumes: Peripheral lines share clk; pin lines are asynchronous and are synchronised.
// Notes:   Configuration bits are plain ports driven by the software model outside.

`timescale 1ns/1ps

module idwp_top
   import idwp_pkg::*;
#(
   parameter int N_SRC = 8,                                  // Number of interrupt sources.
   parameter int N_PIN = 2,                                  // Sources 0..N_PIN-1 are pins.
   parameter int IDX_W = $clog2(N_SRC)                       // Width of a source index.
) (
   input  wire logic                       clk,              // System clock, 200 MHz.
   input  wire logic                       rstn,             // Asynchronous reset, active low.
   input  wire logic [N_SRC-1:0]           periph_irq,       // Peripheral lines, high = request.
   input  wire logic [N_PIN-1:0]           pin_irq,          // Asynchronous external pins.
   input  wire logic [N_PIN-1:0]           pin_input_enable, // Per-pin input enable.
   input  wire logic [N_PIN-1:0]           pin_function_select, // Per-pin function select.
   input  wire logic                       stop_mode,        // Deepest stop mode is active.
   input  wire logic [N_SRC-1:0]           wake_irq_mode_ctrl, // Per-source wake enable.
   input  wire logic [N_SRC*WAKE_SEL_W-1:0] wake_active_state_sel, // Per-source active state.
   input  wire logic                       wake_irq_clear,   // Pulse: clear one held request.
   input  wire logic [IDX_W-1:0]           wake_clear_code,  // Source code to clear.
   input  wire logic                       prio_wr,          // Pulse: write a priority field.
   input  wire logic [IDX_W-1:0]           prio_idx,         // Source whose priority is written.
   input  wire logic [PRIO_FIELD_W-1:0]    prio_data,        // Priority value 0..255.
   input  wire logic [N_SRC-1:0]           irq_enable,       // Per-source enable in the controller.
   input  wire logic [N_SRC-1:0]           set_pending,      // Pulses: software set-pending.
   input  wire logic [N_SRC-1:0]           clear_pending,    // Pulses: software clear-pending.
   input  wire logic                       global_irq_mask,  // High blocks acceptance.
   input  wire logic                       svc_return,       // Pulse: service routine returns.
   output logic [N_SRC-1:0]                irq_pending_q,    // Pending bits.
   output logic [N_SRC-1:0]                wake_held_q,      // Requests held by the wake detector.
   output logic                            irq_req_q,        // An unmasked request is presented.
   output logic [IDX_W-1:0]                irq_id_q,         // Index of the accepted source.
   output logic                            stack_push_q,     // A context word is pushed.
   output logic [2:0]                      stack_slot_q,     // Which context word is pushed.
   output logic                            svc_enter_q,      // Pulse: routine entry.
   output logic                            svc_active_q      // Routine is running.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [N_PIN-1:0]       pin_s1_q, pin_s2_q, pin_s3_q;     // Pin synchroniser stages.
   logic [N_PIN-1:0]       pin_lvl_q;                        // Filtered pin level.
   logic [N_PIN-1:0]       pin_gate;                         // Pin interrupt input is enabled.
   logic [N_SRC-1:0]       src_raw;                          // Source level before routing.
   logic [N_SRC-1:0]       src_prev_q;                       // Source level one cycle ago.
   logic [N_SRC-1:0]       wake_match, wake_edge, wake_lvl;  // Wake detector terms.
   logic [N_SRC-1:0]       wake_clr_sel;                     // One-hot clear selection.
   logic [N_SRC-1:0]       wake_d;                           // Next held state.
   logic [N_SRC-1:0]       line;                             // Line seen by the controller.
   logic [N_SRC-1:0]       line_prev_q;                      // Line one cycle ago.
   logic [N_SRC-1:0]       line_rise;                        // Rising edge on a line.
   logic [N_SRC-1:0]       cand;                             // Pending and enabled.
   logic [N_SRC-1:0]       acc_clr;                          // Pending bit cleared on acceptance.
   logic [N_SRC-1:0]       pend_d;                           // Next pending state.
   logic [PRIO_IMPL_W-1:0] prio_q [N_SRC];                   // Implemented priority bits.
   logic [N_SRC*PRIO_IMPL_W-1:0] prio_flat;                  // Priorities packed, source 0 lowest.
   logic [IDX_W:0]         pick;                             // Arbiter result {valid, index}.
   logic                   best_valid;                       // Some source is a candidate.
   logic [IDX_W-1:0]       best_idx;                         // Winning source.
   logic                   accept;                           // Request accepted this cycle.
   idwp_state_e            state_q, state_d;                 // Acceptance sequencer.
   logic [2:0]             cnt_q, cnt_d;                     // Context word counter.
   logic [N_SRC-1:0]       keep_mask;                        // Edge holds not being cleared.

   ////////////////////////////////////////////////////////////////////////////////
   // Arbiter: lowest priority value wins; scanning downward with <= lets
   // the lower index win a tie.
   function automatic logic [IDX_W:0] idwp_best(input logic [N_SRC-1:0] c,
                                                input logic [N_SRC*PRIO_IMPL_W-1:0] p);
      logic             found;
      logic [IDX_W-1:0] idx;
      logic [2:0]       bp;
      found = 1'b0;
      idx   = '0;
      bp    = 3'h7;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (c[i] && (!found || p[i*PRIO_IMPL_W +: PRIO_IMPL_W] <= bp)) begin
            found = 1'b1;
            idx   = IDX_W'(i);
            bp    = p[i*PRIO_IMPL_W +: PRIO_IMPL_W];
         end
      end
      return {found, idx};
   endfunction : idwp_best

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser: a change counts once stages two and three agree.
   // Stage one may settle late, so only stages two and three are compared.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_q  <= '0;
         pin_s2_q  <= '0;
         pin_s3_q  <= '0;
         pin_lvl_q <= '0;
      end else begin
         pin_s1_q  <= pin_irq;
         pin_s2_q  <= pin_s1_q;
         pin_s3_q  <= pin_s2_q;
         pin_lvl_q <= (pin_s3_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_lvl_q & (pin_s2_q ^ pin_s3_q));
      end
   end

   // Outside stop the input enable alone opens the pin; in stop mode the
   // function select is needed as well.
   assign pin_gate = stop_mode ? (pin_input_enable & pin_function_select)
                               : pin_input_enable;

   // Pins occupy the lowest source numbers and are ORed onto their lines.
   assign src_raw = periph_irq | {{(N_SRC-N_PIN){1'b0}}, pin_lvl_q & pin_gate};

   ////////////////////////////////////////////////////////////////////////////////
   // Wake detector: each source picks its own active state and enable.
   genvar g;
   generate
      for (g = 0; g < N_SRC; g++) begin : g_wake
         wire [2:0] sel = wake_active_state_sel[g*WAKE_SEL_W +: WAKE_SEL_W];
         assign wake_lvl[g]   = (sel == WAKE_HIGH) ? src_raw[g]
                              : (sel == WAKE_LOW)  ? ~src_raw[g] : 1'b0;
         assign wake_edge[g]  = (sel == WAKE_RISE) ? (src_raw[g] & ~src_prev_q[g])
                              : (sel == WAKE_FALL) ? (~src_raw[g] & src_prev_q[g]) : 1'b0;
         assign wake_match[g] = (sel == WAKE_RISE) || (sel == WAKE_FALL);
      end
   endgenerate

   // Only the source named by the written code is cleared.
   assign wake_clr_sel = wake_irq_clear ? (N_SRC'(1) << wake_clear_code) : '0;

   // Edge requests latch until cleared, and a new edge wins over a clear in
   // the same cycle; level requests follow the input and vanish with it.
   assign wake_d = wake_irq_mode_ctrl &
                   ((wake_match & (wake_edge | (wake_held_q & ~wake_clr_sel)))
                  | (~wake_match & wake_lvl));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         src_prev_q  <= '0;
         wake_held_q <= '0;
      end else begin
         src_prev_q  <= src_raw;
         wake_held_q <= wake_d;
      end
   end

   // Wake-enabled lines reach the controller only through the detector.
   assign line = (wake_irq_mode_ctrl & wake_held_q) | (~wake_irq_mode_ctrl & src_raw);

   // Flatten the priority store so the arbiter can slice it by source
   // number; source 0 sits in the lowest three bits.
   generate
      for (g = 0; g < N_SRC; g++) begin : g_prio_flat
         assign prio_flat[g*PRIO_IMPL_W +: PRIO_IMPL_W] = prio_q[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Pending logic: rising lines and software set-pending both set a bit.
   assign line_rise = line & ~line_prev_q;
   assign cand      = irq_pending_q & irq_enable;
   assign pick      = idwp_best(cand, prio_flat);
   assign best_valid = pick[IDX_W];
   assign best_idx   = pick[IDX_W-1:0];
   assign accept    = (state_q == IDWP_IDLE) && best_valid && !global_irq_mask;
   assign acc_clr   = accept ? (N_SRC'(1) << best_idx) : '0;
   // A set in the same cycle as any clear wins.
   assign pend_d    = line_rise | set_pending
                    | (irq_pending_q & ~clear_pending & ~acc_clr);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         line_prev_q   <= '0;
         irq_pending_q <= '0;
      end else begin
         line_prev_q   <= line;
         irq_pending_q <= pend_d;
      end
   end

   // Priority store keeps only the top three bits of the written field.
   // The low five bits are dropped, so values 0 to 31 all share level 0.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < N_SRC; i++) prio_q[i] <= PRIO_RESET;
      end else if (prio_wr) begin
         prio_q[prio_idx] <= prio_data[PRIO_MSB:PRIO_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Acceptance sequencer: accept, push eight context words, run the routine.
   // There is no preemption: a request that arrives meanwhile waits in pending
   // and is arbitrated again once the routine returns.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         IDWP_IDLE: begin
            cnt_d = STACK_FIRST;
            if (accept) begin
               state_d = IDWP_STACK;
            end
         end
         IDWP_STACK: begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == STACK_LAST) begin
               state_d = IDWP_SERVICE;
            end
         end
         IDWP_SERVICE: begin
            if (svc_return) begin
               state_d = IDWP_IDLE;
            end
         end
         default: begin
            state_d = IDWP_IDLE;
         end
      endcase
   end

   // Sequencer state and registered outputs toward the processor.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q      <= IDWP_IDLE;
         cnt_q        <= STACK_FIRST;
         irq_req_q    <= 1'b0;
         irq_id_q     <= '0;
         stack_push_q <= 1'b0;
         stack_slot_q <= STACK_FIRST;
         svc_enter_q  <= 1'b0;
         svc_active_q <= 1'b0;
      end else begin
         state_q      <= state_d;
         cnt_q        <= cnt_d;
         irq_req_q    <= best_valid && !global_irq_mask;
         irq_id_q     <= accept ? best_idx : irq_id_q;
         stack_push_q <= (state_q == IDWP_STACK);
         stack_slot_q <= cnt_q;
         svc_enter_q  <= stack_push_q && (stack_slot_q == STACK_LAST);
         // Running only once the last context word is out, never beside it.
         svc_active_q <= (state_q == IDWP_SERVICE) && !svc_return;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   assign keep_mask = wake_held_q & wake_match & wake_irq_mode_ctrl & ~wake_clr_sel;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Stacking may only start from an acceptance made while unmasked.
   a_mask_blocks:   assert property (
      $rose(stack_push_q) |-> !$past(global_irq_mask, 2))
      else $error("Request accepted while globally masked.");
   a_req_masked:    assert property (global_irq_mask |=> !irq_req_q)
      else $error("Request presented while globally masked.");
   a_stack_eight:   assert property (
      $rose(stack_push_q) |-> stack_push_q [*8] ##1 svc_enter_q)
      else $error("Context stacking did not take eight words before entry.");
   a_stack_first:   assert property (stack_push_q |-> !svc_active_q)
      else $error("Routine marked running while context is still pushed.");
   a_pick_cand:     assert property (accept |-> cand[best_idx])
      else $error("Accepted source was not a candidate.");
   a_tie_lowest:    assert property (
      accept && cand[0] && prio_q[0] == PRIO_RESET |-> best_idx == '0)
      else $error("Tie not resolved toward the lowest index.");
   a_prio_bits:     assert property (
      prio_wr |=> prio_q[$past(prio_idx)] == $past(prio_data[PRIO_MSB:PRIO_LSB]))
      else $error("Priority field not stored from its top three bits.");
   a_hw_pend:       assert property (
      |line_rise |=> (irq_pending_q & $past(line_rise)) == $past(line_rise))
      else $error("Rising line did not set pending.");
   a_sw_pend:       assert property (
      |set_pending |=> (irq_pending_q & $past(set_pending)) == $past(set_pending))
      else $error("Software set-pending did not set pending.");
   a_wake_keep:     assert property (
      |keep_mask |=> (wake_held_q & $past(keep_mask)) == $past(keep_mask))
      else $error("Held wake request dropped without its own clear.");
   a_wake_route:    assert property ((line & wake_irq_mode_ctrl & ~wake_held_q) == '0)
      else $error("Wake-routed line bypassed the detector.");

endmodule : idwp_top

// ---- rtl/idwp_pkg.sv ----
// Purpose: Shared constants for the interrupt detect and wake path.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Wake active-state codes are three bits wide per source.

package idwp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Priority field layout: eight bits written, top three kept.
   localparam int          PRIO_FIELD_W = 8;       // Width of a written priority field.
   localparam int          PRIO_IMPL_W  = 3;       // Bits that take part in arbitration.
   localparam int          PRIO_MSB     = 7;       // Highest kept bit of the field.
   localparam int          PRIO_LSB     = 5;       // Lowest kept bit of the field.
   localparam logic [2:0]  PRIO_RESET   = 3'h0;    // Priority after reset.

   ////////////////////////////////////////////////////////////////////////////////
   // Wake detector active-state selection codes.
   localparam int          WAKE_SEL_W   = 3;       // Width of one active-state field.
   localparam logic [2:0]  WAKE_LOW     = 3'h0;    // Low level is active.
   localparam logic [2:0]  WAKE_HIGH    = 3'h1;    // High level is active.
   localparam logic [2:0]  WAKE_FALL    = 3'h2;    // Falling edge is active.
   localparam logic [2:0]  WAKE_RISE    = 3'h3;    // Rising edge is active.

   ////////////////////////////////////////////////////////////////////////////////
   // Context stacking: PC, PSR, r0-r3, r12 and LR.
   localparam int          STACK_WORDS  = 8;       // Words pushed before the service routine.
   localparam logic [2:0]  STACK_LAST   = 3'h7;    // Index of the last pushed word.
   localparam logic [2:0]  STACK_FIRST  = 3'h0;    // Index of the first pushed word.

   ////////////////////////////////////////////////////////////////////////////////
   // Acceptance sequencer states.
   typedef enum logic [1:0] {
      IDWP_IDLE    = 2'b00,                        // Waiting for an unmasked request.
      IDWP_STACK   = 2'b01,                        // Pushing the register context.
      IDWP_SERVICE = 2'b10                         // Service routine is running.
   } idwp_state_e;

endpackage : idwp_pkg

// ---- testbench/idwp_src_model.sv ----
// Purpose: Model of the peripheral sources and of the core's return path.
// Assumes: Peripheral lines share clk and rest low between requests.
// Notes:   A fired source holds its line high for two cycles, then drops it.
`timescale 1ns/1ps

module idwp_src_model #(
   parameter int N_SRC = 8                       // Number of interrupt sources.
) (
   input  wire logic             clk,            // System clock.
   input  wire logic             rstn,           // Asynchronous reset, active low.
   input  wire logic [N_SRC-1:0] fire,           // One-cycle command to raise a request.
   input  wire logic [3:0]       ret_dly,        // Extra cycles spent in the routine.
   input  wire logic             svc_enter_q,    // Routine entry pulse from the block.
   output logic      [N_SRC-1:0] periph_irq,     // Request lines, high means request.
   output logic                  svc_return      // One-cycle return from the routine.
);
   logic [N_SRC-1:0] hold_q;                     // Second cycle of each raised line.
   logic [4:0]       run_q;                      // Cycles left in the routine, zero is none.

   // A request is a clean low-to-high step that stays up long enough to be seen.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_q     <= '0;
         periph_irq <= '0;
      end else begin
         hold_q     <= fire;
         periph_irq <= fire | hold_q;
      end
   end

   // The routine lasts a chosen time, set by ret_dly and the same for every routine of a run.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run_q      <= 5'h00;
         svc_return <= 1'b0;
      end else begin
         svc_return <= (run_q == 5'h01);
         if (svc_enter_q) begin
            run_q <= {1'b0, ret_dly} + 5'h02;
         end else if (run_q != 5'h00) begin
            run_q <= run_q - 5'h01;
         end
      end
   end
endmodule : idwp_src_model

// ---- testbench/test_idwp_top.sv ----
// Purpose: Self-checking bench for the interrupt detect and wake path.
// Assumes: Eight sources, two pins, 200 MHz clock.
// Notes:   The driver queues expected routine entries; a monitor checks them.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

module test_idwp_top;
   import idwp_pkg::*;
   logic clk, rstn, stop_mode, wake_irq_clear, prio_wr, global_irq_mask, svc_return;
   logic [7:0]  periph_irq, wake_irq_mode_ctrl, irq_enable, set_pending, clear_pending, fire;
   logic [7:0]  irq_pending_q, wake_held_q, prio_data;
   logic [1:0]  pin_irq, pin_input_enable, pin_function_select;
   logic [23:0] wake_active_state_sel;           // Three-bit code per source.
   logic [2:0]  wake_clear_code, prio_idx, irq_id_q, stack_slot_q, pop_id;
   logic        irq_req_q, stack_push_q, svc_enter_q, svc_active_q;
   logic [3:0]  ret_dly, push_cnt;               // Routine length and pushes seen.
   logic [31:0] seed, r;                         // Random state and last draw.
   logic [2:0]  codes [4] = '{WAKE_LOW, WAKE_HIGH, WAKE_FALL, WAKE_RISE};
   logic [2:0]  exp_id [$];                      // Expected accepted sources, oldest first.
   int          miscompares, compares;

   idwp_top dut (.clk(clk), .rstn(rstn), .periph_irq(periph_irq), .pin_irq(pin_irq),
      .pin_input_enable(pin_input_enable), .pin_function_select(pin_function_select),
      .stop_mode(stop_mode), .wake_irq_mode_ctrl(wake_irq_mode_ctrl),
      .wake_active_state_sel(wake_active_state_sel), .wake_irq_clear(wake_irq_clear),
      .wake_clear_code(wake_clear_code), .prio_wr(prio_wr), .prio_idx(prio_idx),
      .prio_data(prio_data), .irq_enable(irq_enable), .set_pending(set_pending),
      .clear_pending(clear_pending), .global_irq_mask(global_irq_mask),
      .svc_return(svc_return), .irq_pending_q(irq_pending_q), .wake_held_q(wake_held_q),
      .irq_req_q(irq_req_q), .irq_id_q(irq_id_q), .stack_push_q(stack_push_q),
      .stack_slot_q(stack_slot_q), .svc_enter_q(svc_enter_q), .svc_active_q(svc_active_q));

   idwp_src_model #(.N_SRC(8)) partner (.clk(clk), .rstn(rstn), .fire(fire),
      .ret_dly(ret_dly), .svc_enter_q(svc_enter_q), .periph_irq(periph_irq),
      .svc_return(svc_return));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 5 ns period.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Xorshift draw; the state starts at 66.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // Step past the edge so registered outputs have settled.
   task automatic look();
      @(posedge clk);
      #1;
   endtask : look

   task automatic prio(input logic [2:0] idx, input logic [7:0] v);
      @(posedge clk);
      prio_wr <= 1'b1;
      prio_idx <= idx;
      prio_data <= v;
      @(posedge clk);
      prio_wr <= 1'b0;
   endtask : prio

   task automatic wclr(input logic [2:0] code);
      @(posedge clk);
      wake_irq_clear <= 1'b1;
      wake_clear_code <= code;
      @(posedge clk);
      wake_irq_clear <= 1'b0;
   endtask : wclr

   task automatic pend(input logic [7:0] s, input logic [7:0] c);
      @(posedge clk);
      set_pending <= s;
      clear_pending <= c;
      @(posedge clk);
      set_pending <= 8'h00;
      clear_pending <= 8'h00;
   endtask : pend

   // Bounded wait until every queued entry is taken and the routine is over.
   task automatic drain();
      for (int i = 0; i < 600 && !(exp_id.size() == 0 && svc_active_q === 1'b0); i++) begin
         @(posedge clk);
      end
      `CHK({svc_active_q, exp_id.size() == 0}, 2'b01)
   endtask : drain

   task automatic complete_run();
      if (exp_id.size() != 0) miscompares++;
      $display("comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: counts context pushes and checks each entry against the oldest note.
   always @(posedge clk) begin
      if (rstn && stack_push_q === 1'b1) begin
         `CHK(stack_slot_q, push_cnt[2:0])
         push_cnt = push_cnt + 4'h1;
      end
      if (rstn && svc_enter_q === 1'b1) begin
         `CHK(push_cnt, 4'h8)
         push_cnt = 4'h0;
         pop_id = (exp_id.size() != 0) ? exp_id.pop_front() : 3'hx;
         `CHK(irq_id_q, pop_id)
      end
   end

   // Watchdog against a hang.
   initial begin
      #100000;
      miscompares++;
      $display("unexpected at %0t: timeout", $time);
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      {rstn, stop_mode, wake_irq_clear, prio_wr, fire, ret_dly, push_cnt} = '0;
      {wake_irq_mode_ctrl, set_pending, clear_pending, prio_data} = '0;
      {pin_irq, pin_function_select, wake_active_state_sel, wake_clear_code, prio_idx} = '0;
      global_irq_mask = 1'b1;
      irq_enable = 8'hff;
      pin_input_enable = 2'b11;
      seed = 32'h42;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      look();
      `CHK({irq_pending_q, wake_held_q, irq_req_q, stack_push_q, svc_active_q}, 19'h0)
      // Pin path in and out of stop mode, processor masked first.
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         stop_mode <= (k < 2);
         pin_function_select[0] <= (k == 1);
         pin_irq[0] <= 1'b1;
         tick(8);
         pin_irq[0] <= 1'b0;
         tick(8);
         look();
         `CHK(irq_pending_q[0], (k != 0))
         `CHK(irq_req_q, 1'b0)
         pend(8'h00, 8'hff);
      end
      stop_mode <= 1'b0;
      // A second held request on source 4 must survive clears aimed at source 1.
      wake_active_state_sel[12 +: 3] <= WAKE_RISE;
      wclr(3'h4);
      wake_irq_mode_ctrl[4] <= 1'b1;
      @(posedge clk) fire <= 8'h10;
      @(posedge clk) fire <= 8'h00;
      // Every active-state code on pin source 1: state, clear, then enable.
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         wake_irq_mode_ctrl[1] <= 1'b0;
         wake_active_state_sel[3 +: 3] <= codes[k];
         pin_irq[1] <= !codes[k][0];
         tick(8);
         wclr(3'h1);
         pend(8'h00, 8'hff);
         wake_irq_mode_ctrl[1] <= 1'b1;
         tick(8);
         look();
         `CHK(wake_held_q[1], 1'b0)
         @(posedge clk) pin_irq[1] <= codes[k][0];
         tick(8);
         look();
         `CHK(wake_held_q[1], 1'b1)
         `CHK(irq_pending_q[1], 1'b1)
         @(posedge clk) pin_irq[1] <= !codes[k][0];
         tick(16);
         look();
         `CHK(wake_held_q[1], codes[k][1])
         wclr(3'h1);
         tick(2);
         look();
         `CHK(wake_held_q[1], 1'b0)
         `CHK(wake_held_q[4], 1'b1)
      end
      @(posedge clk) wake_irq_mode_ctrl <= 8'h00;
      wclr(3'h4);
      pend(8'h00, 8'hff);
      // Arbitration: only the top three bits count, ties go to the lower index.
      seed = xs(seed);
      r    = seed;
      prio(3'h3, 8'h1f);
      prio(3'h5, {3'h0, r[4:0]});
      prio(3'h2, 8'h20);
      prio(3'h7, 8'hff);
      pend(8'hac, 8'h00);
      tick(4);
      look();
      `CHK(irq_req_q, 1'b0)
      `CHK(irq_pending_q, 8'hac)
      exp_id = '{3'h3, 3'h5, 3'h2, 3'h7};
      @(posedge clk);
      ret_dly <= r[11:8];
      global_irq_mask <= 1'b0;
      look();
      `CHK({irq_req_q, irq_id_q}, 4'hb)
      drain();
      // A peripheral line step is taken as a request.
      exp_id.push_back(3'h6);
      @(posedge clk) fire <= 8'h40;
      @(posedge clk) fire <= 8'h00;
      drain();
      complete_run();
   end
endmodule : test_idwp_top
